// ### logic/ekd_pkg.sv
// constants for the enclave key derivation block
package ekd_pkg;
   // register byte offsets (low address bits only)
   localparam int          AW       = 8;
   localparam logic [7:0]  A_CTRL   = 8'h00;
   localparam logic [7:0]  A_STAT   = 8'h04;
   localparam logic [7:0]  A_FLAGS  = 8'h08;
   localparam logic [7:0]  A_LEAF   = 8'h0c;
   localparam logic [7:0]  A_RBX    = 8'h10;
   localparam logic [7:0]  A_RCX    = 8'h14;
   localparam logic [7:0]  A_RAX    = 8'h18;
   localparam logic [7:0]  A_KTYPE  = 8'h1c;
   localparam logic [7:0]  A_RSVN   = 8'h20;
   localparam logic [7:0]  A_RCPU   = 8'h24;
   localparam logic [7:0]  A_AMASK  = 8'h28;
   localparam logic [7:0]  A_MMASK  = 8'h2c;
   localparam logic [7:0]  A_NONCE  = 8'h30;
   localparam logic [7:0]  A_EATTR  = 8'h34;
   localparam logic [7:0]  A_EMISC  = 8'h38;
   localparam logic [7:0]  A_ESVN   = 8'h3c;
   localparam logic [7:0]  A_EMEAS  = 8'h40;
   localparam logic [7:0]  A_ESIGN  = 8'h44;
   localparam logic [7:0]  A_EPROD  = 8'h48;
   localparam logic [7:0]  A_EEXT   = 8'h4c;
   localparam logic [7:0]  A_EFAM   = 8'h50;
   localparam logic [7:0]  A_ECFG   = 8'h54;
   localparam logic [7:0]  A_EPOCH  = 8'h58;
   localparam logic [7:0]  A_PCPU   = 8'h5c;
   localparam logic [7:0]  A_KADDR  = 8'h60;
   localparam logic [3:0]  A_KEYHI  = 4'h7;
   // bit positions, flag values and the word transfer size
   localparam int          C_START  = 0;
   localparam int          C_ENCL   = 1;
   localparam int          S_BUSY   = 0;
   localparam int          S_DONE   = 1;
   localparam int          S_GP     = 2;
   localparam int          F_ZF     = 0;
   localparam logic [5:0]  FLAGS_OK = 6'h00;
   localparam logic [5:0]  FLAGS_ER = 6'h01;
   localparam int          ATTR_PROV = 4;
   localparam int          ATTR_LTK  = 5;
   localparam logic [2:0]  SZ_WORD  = 3'h2;
   // request decode
   localparam logic [31:0] LEAF_KEY = 32'h0000_0001;
   localparam int          RBX_ALN  = 9;
   localparam int          RCX_ALN  = 4;
   localparam logic [31:0] REQ_SEAL_MASK = 32'h0000_0003;
   localparam logic [31:0] RAX_OK   = 32'h0000_0000;
   // error codes: values are arbitrary
   localparam logic [31:0] ERR_ATTR = 32'h0000_0001;
   localparam logic [31:0] ERR_SVN  = 32'h0000_0002;
   localparam logic [31:0] ERR_TYPE = 32'h0000_0003;
   // key types
   localparam logic [15:0] KT_LTOK  = 16'h0000;
   localparam logic [15:0] KT_PROV  = 16'h0001;
   localparam logic [15:0] KT_PSEAL = 16'h0002;
   localparam logic [15:0] KT_REPT  = 16'h0003;
   localparam logic [15:0] KT_SEAL  = 16'h0004;
   // derivation fields: 0 attr 1 epoch 2 cpu 3 sw 4 prod 5 ext 6 fam 7 meas 8 signer 9 cfgid 10 cfgsvn 11 rand
   localparam int          NF       = 12;
   localparam int          FD_CPU   = 2;
   localparam int          FD_SW    = 3;
   localparam int          FD_CSVN  = 10;
   localparam logic [NF-1:0] GATED  = 12'h3f0;
   localparam logic [4:0][NF-1:0] YES_TBL = {12'h002, 12'h687, 12'h900, 12'h910, 12'h112};
   localparam logic [4:0][NF-1:0] REQ_TBL = {12'hffd, 12'h800, 12'h67d, 12'h00d, 12'h80d};
   localparam int          ROUNDS   = 16;
   typedef enum logic [1:0] {ST_IDLE, ST_CHK, ST_MIX} ekd_st_e;
endpackage

// ### logic/ekd_key_derive.sv
// key fetch leaf: operand checks, field assembly and key mixing behind an AHB-Lite slave
//
// Behaviour
// - leaf number one selects key retrieval
// - success yields a 128-bit secret key
// - request at rbx, key returned at rcx
// - outside enclave raises general protection fault
// - assemble data, mix with secret, write out
// - misaligned operand raises general protection fault
// - success clears zf cf af of sf pf
// - errors set zf, code in rax, no output
// - one error reported, order is implementation's
// - key type selector picks the key
// - key combines enclave values and processor key
// - default fields come from enclave sources
// - request fields come from the request
// - request address must be 512-byte aligned
// - output address must be 16-byte aligned
// - init and debug attributes always folded in
// - missing required attribute gives attribute error
`timescale 1ns/100ps
module ekd_key_derive #(
   parameter logic [127:0] SECRET = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0, // arbitrary
   parameter int           ROUNDS = ekd_pkg::ROUNDS
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   typedef struct packed {
      logic [31:0]     hrdata;
      logic            hready;
      logic            hresp;
      logic            wr_pend;
      logic [7:0]      wr_addr;
      ekd_pkg::ekd_st_e st;
      logic [7:0]      cnt;
      logic            busy;
      logic            done;
      logic            gp;
      logic            in_enc;
      logic [5:0]      flags;
      logic [31:0]     leaf;
      logic [31:0]     rbx;
      logic [31:0]     rcx;
      logic [31:0]     rax;
      logic [15:0]     key_type;
      logic [15:0]     policy;
      logic [31:0]     req_svn;
      logic [31:0]     req_cpu;
      logic [31:0]     amask;
      logic [31:0]     mmask;
      logic [31:0]     nonce;
      logic [31:0]     enc_attr;
      logic [31:0]     enc_misc;
      logic [31:0]     enc_svn;
      logic [31:0]     enc_meas;
      logic [31:0]     enc_sign;
      logic [31:0]     enc_prod;
      logic [31:0]     enc_ext;
      logic [31:0]     enc_fam;
      logic [31:0]     enc_cfg;
      logic [31:0]     epoch;
      logic [31:0]     plat_cpu;
      logic [31:0]     key_addr;
      logic [127:0]    acc;
      logic [127:0]    key;
   } ekd_state_s;

   localparam int NF_W = ekd_pkg::NF;

   ekd_state_s            r_q;
   ekd_state_s            r_d;
   logic [NF_W-1:0]       yes_c;
   logic [NF_W-1:0]       req_c;
   logic [31:0]           ysrc [NF_W];
   logic [31:0]           rsrc [NF_W];
   logic [32*NF_W-1:0]    flat_c;
   logic [127:0]          dep_c;
   logic [127:0]          mix_c;
   logic [127:0]          mx_s;
   logic [31:0]           rd_c;
   logic                  gp_c;
   logic                  type_bad_c;
   logic                  attr_bad_c;
   logic                  svn_bad_c;

   // key type picks its column of yes/request marks
   always_comb
   begin
      yes_c = '0;
      req_c = '0;
      if (!type_bad_c)
      begin
         yes_c = ekd_pkg::YES_TBL[r_q.key_type[2:0]];
         req_c = ekd_pkg::REQ_TBL[r_q.key_type[2:0]];
      end
   end

   // default sources and request sources, one per field
   assign ysrc[0]  = r_q.enc_attr ^ {r_q.enc_misc[15:0], r_q.enc_misc[31:16]};
   assign rsrc[0]  = ((r_q.amask | ekd_pkg::REQ_SEAL_MASK) & r_q.enc_attr) ^
                     {r_q.mmask[15:0] & r_q.enc_misc[15:0], r_q.mmask[31:16] & r_q.enc_misc[31:16]};
   assign ysrc[1]  = r_q.epoch;
   assign rsrc[1]  = r_q.epoch;
   assign ysrc[2]  = r_q.plat_cpu;
   assign rsrc[2]  = r_q.req_cpu;
   assign ysrc[3]  = {16'h0000, r_q.enc_svn[15:0]};
   assign rsrc[3]  = {16'h0000, r_q.req_svn[15:0]};
   assign ysrc[4]  = r_q.enc_prod;
   assign rsrc[4]  = r_q.enc_prod;
   assign ysrc[5]  = r_q.enc_ext;
   assign rsrc[5]  = r_q.enc_ext;
   assign ysrc[6]  = r_q.enc_fam;
   assign rsrc[6]  = r_q.enc_fam;
   assign ysrc[7]  = r_q.enc_meas;
   assign rsrc[7]  = r_q.enc_meas;
   assign ysrc[8]  = r_q.enc_sign;
   assign rsrc[8]  = r_q.enc_sign;
   assign ysrc[9]  = r_q.enc_cfg;
   assign rsrc[9]  = r_q.enc_cfg;
   assign ysrc[10] = {16'h0000, r_q.enc_svn[31:16]};
   assign rsrc[10] = {16'h0000, r_q.req_svn[31:16]};
   assign ysrc[11] = r_q.nonce;
   assign rsrc[11] = r_q.nonce;

   // identity fields marked request are only taken when the request's policy bit asks for them
   for (genvar i = 0; i < NF_W; i++)
   begin : g_field
      always_comb
      begin
         if (yes_c[i])
            flat_c[32*i +: 32] = ysrc[i];
         else if (req_c[i] && (!ekd_pkg::GATED[i] || r_q.policy[i]))
            flat_c[32*i +: 32] = rsrc[i];
         else
            flat_c[32*i +: 32] = 32'h0000_0000;
      end
   end

   assign dep_c = flat_c[127:0] ^ flat_c[255:128] ^ flat_c[383:256] ^ {112'h0, r_q.key_type};

   // toy keyed permutation; not a real cipher, just a stand-in for the derivation engine
   assign mx_s  = r_q.acc ^ SECRET;
   assign mix_c = {mx_s[120:0], mx_s[127:121]} + {mx_s[63:0], mx_s[127:64]} + {120'h0, r_q.cnt};

   // operand and request checks
   assign gp_c = (r_q.leaf != ekd_pkg::LEAF_KEY)
              || !r_q.in_enc
              || (r_q.rbx[ekd_pkg::RBX_ALN-1:0] != '0)
              || (r_q.rcx[ekd_pkg::RCX_ALN-1:0] != '0);
   assign type_bad_c = r_q.key_type > ekd_pkg::KT_SEAL;
   assign attr_bad_c = (((r_q.key_type == ekd_pkg::KT_PROV) || (r_q.key_type == ekd_pkg::KT_PSEAL))
                        && !r_q.enc_attr[ekd_pkg::ATTR_PROV])
                    || ((r_q.key_type == ekd_pkg::KT_LTOK) && !r_q.enc_attr[ekd_pkg::ATTR_LTK]);
   assign svn_bad_c  = (req_c[ekd_pkg::FD_CPU] && (r_q.req_cpu > r_q.plat_cpu))
                    || (req_c[ekd_pkg::FD_SW] && (r_q.req_svn[15:0] > r_q.enc_svn[15:0]))
                    || (req_c[ekd_pkg::FD_CSVN] && (r_q.req_svn[31:16] > r_q.enc_svn[31:16]));

   // register read mux
   always_comb
   begin
      case (haddr[ekd_pkg::AW-1:0])
         ekd_pkg::A_CTRL  : rd_c = {30'h0, r_q.in_enc, 1'b0};
         ekd_pkg::A_STAT  : rd_c = {29'h0, r_q.gp, r_q.done, r_q.busy};
         ekd_pkg::A_FLAGS : rd_c = {26'h0, r_q.flags};
         ekd_pkg::A_LEAF  : rd_c = r_q.leaf;
         ekd_pkg::A_RBX   : rd_c = r_q.rbx;
         ekd_pkg::A_RCX   : rd_c = r_q.rcx;
         ekd_pkg::A_RAX   : rd_c = r_q.rax;
         ekd_pkg::A_KTYPE : rd_c = {r_q.policy, r_q.key_type};
         ekd_pkg::A_RSVN  : rd_c = r_q.req_svn;
         ekd_pkg::A_RCPU  : rd_c = r_q.req_cpu;
         ekd_pkg::A_AMASK : rd_c = r_q.amask;
         ekd_pkg::A_MMASK : rd_c = r_q.mmask;
         ekd_pkg::A_NONCE : rd_c = r_q.nonce;
         ekd_pkg::A_EATTR : rd_c = r_q.enc_attr;
         ekd_pkg::A_EMISC : rd_c = r_q.enc_misc;
         ekd_pkg::A_ESVN  : rd_c = r_q.enc_svn;
         ekd_pkg::A_EMEAS : rd_c = r_q.enc_meas;
         ekd_pkg::A_ESIGN : rd_c = r_q.enc_sign;
         ekd_pkg::A_EPROD : rd_c = r_q.enc_prod;
         ekd_pkg::A_EEXT  : rd_c = r_q.enc_ext;
         ekd_pkg::A_EFAM  : rd_c = r_q.enc_fam;
         ekd_pkg::A_ECFG  : rd_c = r_q.enc_cfg;
         ekd_pkg::A_EPOCH : rd_c = r_q.epoch;
         ekd_pkg::A_PCPU  : rd_c = r_q.plat_cpu;
         ekd_pkg::A_KADDR : rd_c = r_q.key_addr;
         default          :
         begin
            if (haddr[7:4] == ekd_pkg::A_KEYHI)
               rd_c = r_q.key[32*haddr[3:2] +: 32];
            else
               rd_c = 32'h0000_0000;
         end
      endcase
   end

   always_comb
   begin
      r_d         = r_q;
      r_d.hrdata  = 32'h0000_0000;
      r_d.wr_pend = 1'b0;
      // address phase: whole words only, anything else is ignored with OKAY
      if (hsel && htrans[1] && hready && (hsize == ekd_pkg::SZ_WORD))
      begin
         if (hwrite)
         begin
            r_d.wr_pend = 1'b1;
            r_d.wr_addr = haddr[ekd_pkg::AW-1:0];
         end
         else
            r_d.hrdata = rd_c;
      end
      case (r_q.st)
         ekd_pkg::ST_IDLE : ;
         ekd_pkg::ST_CHK  :
         begin
            r_d.st   = ekd_pkg::ST_IDLE;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            if (gp_c)
               r_d.gp = 1'b1;
            else if (type_bad_c || attr_bad_c || svn_bad_c)
            begin
               r_d.flags = ekd_pkg::FLAGS_ER;
               // fixed priority: type, then attribute, then version
               if (type_bad_c)
                  r_d.rax = ekd_pkg::ERR_TYPE;
               else if (attr_bad_c)
                  r_d.rax = ekd_pkg::ERR_ATTR;
               else
                  r_d.rax = ekd_pkg::ERR_SVN;
            end
            else
            begin
               r_d.st   = ekd_pkg::ST_MIX;
               r_d.busy = 1'b1;
               r_d.done = 1'b0;
               r_d.cnt  = 8'h00;
               r_d.acc  = dep_c;
            end
         end
         ekd_pkg::ST_MIX  :
         begin
            r_d.acc = mix_c;
            r_d.cnt = r_q.cnt + 8'h01;
            if (r_q.cnt == 8'(ROUNDS - 1))
            begin
               r_d.key      = mix_c;
               r_d.key_addr = r_q.rcx;
               r_d.rax      = ekd_pkg::RAX_OK;
               r_d.flags    = ekd_pkg::FLAGS_OK;
               r_d.st       = ekd_pkg::ST_IDLE;
               r_d.busy     = 1'b0;
               r_d.done     = 1'b1;
            end
         end
         default          : r_d.st = ekd_pkg::ST_IDLE;
      endcase
      // data phase of a write
      if (r_q.wr_pend)
      begin
         case (r_q.wr_addr)
            ekd_pkg::A_CTRL  :
            begin
               r_d.in_enc = hwdata[ekd_pkg::C_ENCL];
               if (hwdata[ekd_pkg::C_START] && (r_q.st == ekd_pkg::ST_IDLE))
               begin
                  r_d.st   = ekd_pkg::ST_CHK;
                  r_d.busy = 1'b1;
                  r_d.done = 1'b0;
                  r_d.gp   = 1'b0;
               end
            end
            // a running operation owns the flags, so its result wins over a software write
            ekd_pkg::A_FLAGS :
               if (r_q.st == ekd_pkg::ST_IDLE)
                  r_d.flags = hwdata[5:0];
            ekd_pkg::A_LEAF  : r_d.leaf     = hwdata;
            ekd_pkg::A_RBX   : r_d.rbx      = hwdata;
            ekd_pkg::A_RCX   : r_d.rcx      = hwdata;
            ekd_pkg::A_KTYPE :
            begin
               r_d.key_type = hwdata[15:0];
               r_d.policy   = hwdata[31:16];
            end
            ekd_pkg::A_RSVN  : r_d.req_svn  = hwdata;
            ekd_pkg::A_RCPU  : r_d.req_cpu  = hwdata;
            ekd_pkg::A_AMASK : r_d.amask    = hwdata;
            ekd_pkg::A_MMASK : r_d.mmask    = hwdata;
            ekd_pkg::A_NONCE : r_d.nonce    = hwdata;
            ekd_pkg::A_EATTR : r_d.enc_attr = hwdata;
            ekd_pkg::A_EMISC : r_d.enc_misc = hwdata;
            ekd_pkg::A_ESVN  : r_d.enc_svn  = hwdata;
            ekd_pkg::A_EMEAS : r_d.enc_meas = hwdata;
            ekd_pkg::A_ESIGN : r_d.enc_sign = hwdata;
            ekd_pkg::A_EPROD : r_d.enc_prod = hwdata;
            ekd_pkg::A_EEXT  : r_d.enc_ext  = hwdata;
            ekd_pkg::A_EFAM  : r_d.enc_fam  = hwdata;
            ekd_pkg::A_ECFG  : r_d.enc_cfg  = hwdata;
            ekd_pkg::A_EPOCH : r_d.epoch    = hwdata;
            ekd_pkg::A_PCPU  : r_d.plat_cpu = hwdata;
            default          : ;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         r_q        <= '0;
         r_q.hready <= 1'b1;
         r_q.st     <= ekd_pkg::ST_IDLE;
      end
      else
         r_q <= r_d;
   end

   assign hrdata    = r_q.hrdata;
   assign hreadyout = r_q.hready;
   assign hresp     = r_q.hresp;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   wrong_leaf_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && (r_q.leaf != ekd_pkg::LEAF_KEY) |=> r_q.gp)
      else $error("other leaf did not fault");
   outside_gp_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && !r_q.in_enc |=> r_q.gp && !r_q.busy)
      else $error("outside enclave did not fault");
   req_align_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && (r_q.rbx[ekd_pkg::RBX_ALN-1:0] != '0) |=> r_q.gp)
      else $error("misaligned request address accepted");
   out_align_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && (r_q.rcx[ekd_pkg::RCX_ALN-1:0] != '0) |=> r_q.gp)
      else $error("misaligned output address accepted");
   key_kept_a : assert property ((r_q.st == ekd_pkg::ST_CHK) ##1 (r_q.st == ekd_pkg::ST_IDLE) |-> $stable(r_q.key))
      else $error("key changed on failed request");
   flags_clear_a : assert property ($fell(r_q.busy) && !r_q.gp && (r_q.rax == ekd_pkg::RAX_OK)
      |-> r_q.flags == ekd_pkg::FLAGS_OK)
      else $error("flags not cleared on success");
   bad_type_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && !gp_c && (r_q.key_type > ekd_pkg::KT_SEAL)
      |=> r_q.flags[ekd_pkg::F_ZF] && (r_q.rax == ekd_pkg::ERR_TYPE))
      else $error("bad key type not reported");
   attr_err_a : assert property ((r_q.st == ekd_pkg::ST_CHK) && !gp_c && (r_q.key_type == ekd_pkg::KT_PROV)
      && !r_q.enc_attr[ekd_pkg::ATTR_PROV] |=> r_q.flags[ekd_pkg::F_ZF] && (r_q.rax == ekd_pkg::ERR_ATTR))
      else $error("unauthorised key type not reported");
   key_write_a : assert property ((r_q.st == ekd_pkg::ST_MIX) && (r_q.cnt == 8'(ROUNDS - 1))
      |=> (r_q.key == $past(mix_c)) && (r_q.key_addr == r_q.rcx) && r_q.done)
      else $error("derived key not written out");

endmodule // ekd_key_derive

// ### dv/ekd_sw_model.sv
// enclave software model: issues single-word ahb-lite transfers to the key block
`timescale 1ns/100ps
module ekd_sw_model (
   // clock
   input  wire logic        sys_clk,
   // bus answer
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // bus request
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   initial
   begin
      hsel   = 1'b1;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = ekd_pkg::SZ_WORD;
      hwdata = 32'h0;
   end

   // entered just after a rising edge; released lines show the inverse so stale data never passes
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      haddr  <= ~{24'h0, a};
      hwdata <= w ? d : ~hwdata;
      do @(posedge sys_clk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule // ekd_sw_model

// ### dv/test_ekd_key_derive.sv
// self-checking bench for the key fetch leaf
`timescale 1ns/100ps
module test_ekd_key_derive;
   logic        sys_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          failures = 0;
   int          total_checks = 0;
   logic [127:0] k0, k1, k2;
   localparam logic [7:0]  GA [4] = '{ekd_pkg::A_LEAF, ekd_pkg::A_LEAF, ekd_pkg::A_RBX, ekd_pkg::A_RCX};
   localparam logic [31:0] GB [4] = '{32'h2, 32'h1, 32'h300, 32'h48};
   localparam logic [31:0] GG [4] = '{32'h1, 32'h1, 32'h200, 32'h40};
   localparam logic [31:0] GC [4] = '{32'h3, 32'h1, 32'h3, 32'h3};
   localparam logic [15:0] ET [5] = '{16'h5, 16'h1, 16'h0, 16'h4, 16'h4};
   localparam logic [31:0] EA [5] = '{32'h33, 32'h23, 32'h13, 32'h33, 32'h33};
   localparam logic [31:0] ES [5] = '{32'h20005, 32'h20005, 32'h20005, 32'h20006, 32'h30005};
   localparam logic [31:0] EC [5] = '{ekd_pkg::ERR_TYPE, ekd_pkg::ERR_ATTR, ekd_pkg::ERR_ATTR,
                                      ekd_pkg::ERR_SVN, ekd_pkg::ERR_SVN};

   always #5 sys_clk = ~sys_clk;

   ekd_key_derive #(.ROUNDS(2)) ekd_key_derive_i (
      .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

   ekd_sw_model ekd_sw_model_i (
      .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   // keys are opaque, so only sameness between two derivations is predictable
   task automatic chk_key(input string n, input logic same, input logic [127:0] a, input logic [127:0] b);
      total_checks++;
      if ((a === b) !== same)
      begin
         failures++;
         $display("BAD %s expected same=%0d seen %h vs %h", n, same, a, b);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ekd_sw_model_i.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      ekd_sw_model_i.xfer(1'b0, a, 32'h0, q);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      rd(a, q);
      chk(n, e, q);
   endtask

   task automatic go(input logic [31:0] c);
      logic [31:0] s;
      int n;
      wr(ekd_pkg::A_CTRL, c);
      n = 0;
      do
      begin
         rd(ekd_pkg::A_STAT, s);
         n++;
      end
      while (s[ekd_pkg::S_DONE] !== 1'b1 && n < 40);
      chk("done", 32'h1, {31'h0, s[ekd_pkg::S_DONE]});
   endtask

   task automatic getkey(output logic [127:0] k);
      logic [31:0] q;
      for (int i = 0; i < 4; i++)
      begin
         rd({ekd_pkg::A_KEYHI, i[1:0], 2'b00}, q);
         k[32*i +: 32] = q;
      end
   endtask

   task automatic key_run(input logic [15:0] kt, output logic [127:0] k);
      wr(ekd_pkg::A_KTYPE, {16'h03f0, kt});
      go(32'h3);
      getkey(k);
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      close_out;
   end

   initial
   begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rchk(ekd_pkg::A_STAT, 32'h0, "stat_reset");
      rchk(8'h64, 32'h0, "unmapped");
      wr(ekd_pkg::A_EATTR, 32'h33);
      wr(ekd_pkg::A_ESVN, 32'h20005);
      wr(ekd_pkg::A_PCPU, 32'h7);
      wr(ekd_pkg::A_EPROD, 32'h11);
      wr(ekd_pkg::A_EMEAS, 32'h22);
      wr(ekd_pkg::A_ESIGN, 32'h44);
      wr(ekd_pkg::A_ECFG, 32'h55);
      wr(ekd_pkg::A_EPOCH, 32'h66);
      wr(ekd_pkg::A_LEAF, ekd_pkg::LEAF_KEY);
      wr(ekd_pkg::A_RBX, 32'h200);
      wr(ekd_pkg::A_RCX, 32'h40);
      wr(ekd_pkg::A_RSVN, 32'h20005);
      wr(ekd_pkg::A_RCPU, 32'h7);
      wr(ekd_pkg::A_AMASK, 32'h3);
      wr(ekd_pkg::A_FLAGS, 32'h2a);
      for (int i = 0; i < 4; i++)
      begin
         wr(GA[i], GB[i]);
         go(GC[i]);
         rchk(ekd_pkg::A_STAT, 32'h6, "stat_fault");
         rchk(ekd_pkg::A_FLAGS, 32'h2a, "flags_fault");
         wr(GA[i], GG[i]);
      end
      getkey(k0);
      chk_key("key_fault", 1'b1, k0, 128'h0);
      wr(ekd_pkg::A_FLAGS, 32'h3f);
      key_run(ekd_pkg::KT_SEAL, k1);
      rchk(ekd_pkg::A_STAT, 32'h2, "stat_ok");
      rchk(ekd_pkg::A_RAX, ekd_pkg::RAX_OK, "rax_ok");
      rchk(ekd_pkg::A_FLAGS, 32'h0, "flags_ok");
      rchk(ekd_pkg::A_KADDR, 32'h40, "kaddr");
      chk_key("key_made", 1'b0, k1, 128'h0);
      wr(ekd_pkg::A_AMASK, 32'h0);
      key_run(ekd_pkg::KT_SEAL, k2);
      chk_key("fold_attr", 1'b1, k1, k2);
      wr(ekd_pkg::A_RCPU, 32'h6);
      key_run(ekd_pkg::KT_SEAL, k2);
      chk_key("seal_cpu", 1'b0, k1, k2);
      key_run(ekd_pkg::KT_REPT, k1);
      chk_key("type_pick", 1'b0, k1, k2);
      wr(ekd_pkg::A_RCPU, 32'h7);
      wr(ekd_pkg::A_RSVN, 32'h30009);
      key_run(ekd_pkg::KT_REPT, k2);
      chk_key("report_cpu", 1'b1, k1, k2);
      rchk(ekd_pkg::A_RAX, ekd_pkg::RAX_OK, "rax_report");
      wr(ekd_pkg::A_RSVN, 32'h20005);
      key_run(ekd_pkg::KT_LTOK, k1);
      wr(ekd_pkg::A_ECFG, 32'h77);
      key_run(ekd_pkg::KT_LTOK, k2);
      chk_key("ltok_cfg", 1'b1, k1, k2);
      wr(ekd_pkg::A_EPROD, 32'h12);
      key_run(ekd_pkg::KT_LTOK, k2);
      chk_key("ltok_prod", 1'b0, k1, k2);
      key_run(ekd_pkg::KT_PROV, k1);
      wr(ekd_pkg::A_EPOCH, 32'h67);
      key_run(ekd_pkg::KT_PROV, k2);
      chk_key("prov_epoch", 1'b1, k1, k2);
      key_run(ekd_pkg::KT_PSEAL, k1);
      rchk(ekd_pkg::A_RAX, ekd_pkg::RAX_OK, "rax_pseal");
      for (int i = 0; i < 5; i++)
      begin
         wr(ekd_pkg::A_EATTR, EA[i]);
         wr(ekd_pkg::A_RSVN, ES[i]);
         wr(ekd_pkg::A_FLAGS, 32'h3e);
         key_run(ET[i], k2);
         rchk(ekd_pkg::A_FLAGS, {26'h0, ekd_pkg::FLAGS_ER}, "flags_err");
         rchk(ekd_pkg::A_RAX, EC[i], "rax_err");
         chk_key("key_kept", 1'b1, k1, k2);
      end
      wr(ekd_pkg::A_EATTR, 32'h33);
      wr(ekd_pkg::A_RSVN, 32'h20005);
      key_run(ekd_pkg::KT_SEAL, k2);
      rchk(ekd_pkg::A_RAX, ekd_pkg::RAX_OK, "rax_recover");
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      close_out;
   end
endmodule // test_ekd_key_derive
